//--- rtl/lock_pkg.sv
// Purpose: constants and carrier types for the guard locking control logic
// Assumes: 50 MHz clock, all sensor and request inputs asynchronous
package lock_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PULSE_MIN_MS = 1500;
  localparam int unsigned PULSE_MAX_MS = 2500;
  localparam int unsigned PROC_MS = 100;
  // all times use the same integer division, with no rounding up; 50 MHz divides evenly
  localparam int unsigned PULSE_MIN_CYC = (CLK_HZ / 1000) * PULSE_MIN_MS;
  localparam int unsigned PULSE_MAX_CYC = (CLK_HZ / 1000) * PULSE_MAX_MS;
  localparam int unsigned PROC_CYC = (CLK_HZ / 1000) * PROC_MS;

  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_AUX_RELEASE = 4'h1;
  localparam logic [3:0] ERR_AUX_NOT_RESTORED = 4'h2;
  localparam logic [3:0] ERR_CROSS_SHORT = 4'h3;
  localparam logic [3:0] ERR_PIN_MISMATCH = 4'h4;

  typedef enum logic [1:0] {
    LK_UNLOCKED,
    LK_LOCKING,
    LK_LOCKED,
    LK_UNLOCKING
  } lock_state_t;

  // sensed conditions from the switch head
  typedef struct packed {
    logic actuator_detected;
    logic pin_locked;
    logic aux_release_active;
    logic aux_restore_bad;
  } sense_t;

  // two safety outputs, driven and read back
  typedef struct packed {
    logic ch1;
    logic ch2;
  } safety_pair_t;

endpackage

//--- rtl/guard_lock_interlock_logic.sv
// Purpose: guard locking toggle, safety output and fault control
// Assumes: rst_n comes from power-on reset only; pin sensed by a sensor
// Notes: fault latches until rst_n; request pulses are measured on the
//   synchronised AND of both request channels
module guard_lock_interlock_logic #(
  parameter int unsigned PULSE_MIN = lock_pkg::PULSE_MIN_CYC,
  parameter int unsigned PULSE_MAX = lock_pkg::PULSE_MAX_CYC,
  parameter int unsigned PROC_TIME = lock_pkg::PROC_CYC
) (
  // clock and power-on reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // solenoid requests from the safety controller
  input  wire logic                   lock_request_ch1,
  input  wire logic                   lock_request_ch2,
  // switch head sensing
  input  wire lock_pkg::sense_t       sense_in,
  // safety output read-back for cross-short monitoring
  input  wire lock_pkg::safety_pair_t safety_readback,
  // outputs
  output      lock_pkg::safety_pair_t safety_output_channel,
  output      logic                   actuator_present_out,
  output      logic                   solenoid_drive,
  output      logic                   fault,
  output      logic [3:0]             error_code
);

  initial begin
    // the processing timer shares the pulse counter width
    if (PULSE_MIN == 0 || PULSE_MIN > PULSE_MAX || PROC_TIME == 0 ||
        PROC_TIME > PULSE_MAX + 1)
      $error("bad timing parameters");
  end

  localparam int CW = $clog2(PULSE_MAX + 2);

  // two-stage synchronisers for every asynchronous input
  localparam int NS = 8;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  assign raw_in = {lock_request_ch1, lock_request_ch2, sense_in,
                   safety_readback};

  always_ff @(posedge clock) begin
    sync1_r <= raw_in;
    sync2_r <= sync1_r;
  end

  wire req_ch1 = sync2_r[7];
  wire req_ch2 = sync2_r[6];
  wire act_det = sync2_r[5];
  wire pin_lck = sync2_r[4];
  wire aux_rel = sync2_r[3];
  wire aux_bad = sync2_r[2];
  wire rb_ch1 = sync2_r[1];
  wire rb_ch2 = sync2_r[0];

  // request pulse measurement
  logic [CW-1:0] pulse_cnt_r;
  logic [CW-1:0] pulse_cnt_nxt;
  wire both_req = req_ch1 & req_ch2;
  wire at_max = (pulse_cnt_r == CW'(PULSE_MAX + 1));
  assign pulse_cnt_nxt = both_req ? (at_max ? pulse_cnt_r
                                            : pulse_cnt_r + CW'(1))
                                  : '0;
  // a valid pulse is recognised at its falling edge, so a stuck-high
  // request never toggles the lock
  wire pulse_ok = !both_req && (pulse_cnt_r >= CW'(PULSE_MIN)) &&
                  (pulse_cnt_r <= CW'(PULSE_MAX));

  always_ff @(posedge clock) begin
    if (!rst_n)
      pulse_cnt_r <= '0;
    else
      pulse_cnt_r <= pulse_cnt_nxt;
  end

  // lock state and processing timer
  lock_pkg::lock_state_t state_r;
  lock_pkg::lock_state_t state_nxt;
  logic [CW-1:0] proc_cnt_r;
  logic fault_r;
  logic [3:0] err_r;
  logic [3:0] err_nxt;

  wire proc_done = (proc_cnt_r == CW'(PROC_TIME - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lock_pkg::LK_UNLOCKED:
        if (pulse_ok) state_nxt = lock_pkg::LK_LOCKING;
      lock_pkg::LK_LOCKING:
        if (proc_done) state_nxt = lock_pkg::LK_LOCKED;
      lock_pkg::LK_LOCKED:
        if (pulse_ok) state_nxt = lock_pkg::LK_UNLOCKING;
      lock_pkg::LK_UNLOCKING:
        if (proc_done) state_nxt = lock_pkg::LK_UNLOCKED;
    endcase
    // a latched fault forces the state, and so the pin, to unlocked
    if (fault_r)
      state_nxt = lock_pkg::LK_UNLOCKED;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= lock_pkg::LK_UNLOCKED;
      proc_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        proc_cnt_r <= '0;
      else if (!proc_done)
        proc_cnt_r <= proc_cnt_r + CW'(1);
    end
  end

  // lock is commanded from the start of the processing time, in LOCKING as well as LOCKED
  wire lock_cmd = (state_r == lock_pkg::LK_LOCKED) ||
                  (state_r == lock_pkg::LK_LOCKING);

  // driven outputs delayed to line up with the two-flop readback path,
  // so an ordinary output edge is not taken for a cross-short
  lock_pkg::safety_pair_t out_d1_r;
  lock_pkg::safety_pair_t out_d2_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_d1_r <= '0;
      out_d2_r <= '0;
    end else begin
      out_d1_r <= safety_output_channel;
      out_d2_r <= out_d1_r;
    end
  end

  // fault detection; only the first cause is recorded
  wire cross_short = (out_d2_r.ch1 != rb_ch1) ||
                     (out_d2_r.ch2 != rb_ch2);
  wire pin_bad = (state_r == lock_pkg::LK_LOCKED) && act_det && !pin_lck;

  always_comb begin
    err_nxt = lock_pkg::ERR_NONE;
    if (aux_rel)
      err_nxt = lock_pkg::ERR_AUX_RELEASE;
    else if (aux_bad)
      err_nxt = lock_pkg::ERR_AUX_NOT_RESTORED;
    else if (cross_short)
      err_nxt = lock_pkg::ERR_CROSS_SHORT;
    else if (pin_bad)
      err_nxt = lock_pkg::ERR_PIN_MISMATCH;
  end

  // only reset clears the latch, which is power-on reset in the system
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
      err_r <= lock_pkg::ERR_NONE;
    end else if (!fault_r && err_nxt != lock_pkg::ERR_NONE) begin
      fault_r <= 1'b1;
      err_r <= err_nxt;
    end
  end

  // safety output and presence flops
  wire outs_on = act_det && pin_lck && !aux_rel && !fault_r &&
                 (state_r == lock_pkg::LK_LOCKED);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      safety_output_channel <= '0;
      actuator_present_out <= 1'b0;
      solenoid_drive <= 1'b0;
    end else begin
      safety_output_channel.ch1 <= outs_on;
      safety_output_channel.ch2 <= outs_on;
      actuator_present_out <= act_det;
      solenoid_drive <= lock_cmd && !fault_r;
    end
  end

  assign fault = fault_r;
  assign error_code = err_r;

endmodule

//--- test/lock_chk.sv
// Purpose: port checks of the guard locking logic
// Assumes: sense and readback inputs reach the outputs three clocks after they change; the end of a request pulse takes four
// Notes: bound to the design below the module
module lock_chk #(parameter int unsigned PROC_TIME = 4) (
  // clock, reset and requests
  input wire logic                   clock, rst_n,
  input wire logic                   lock_request_ch1, lock_request_ch2,
  // sensing and safety pins
  input wire lock_pkg::sense_t       sense_in,
  input wire lock_pkg::safety_pair_t safety_output_channel, safety_readback,
  // status
  input wire logic                   actuator_present_out, solenoid_drive,
  input wire logic                   fault,
  input wire logic [3:0]             error_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic       quiet = !lock_request_ch1 && !lock_request_ch2;
  wire logic [1:0] so = safety_output_channel;
  logic      [5:0] low_r;
  // saturating count of cycles with both requests idle
  always_ff @(posedge clock)
    low_r <= (!rst_n || !quiet) ? 6'h0 : low_r + {5'h0, low_r != 6'h3f};
  chk_chan_pair: assert property (so[0] == so[1])
    else $error("safety channels differ");
  chk_out_cause: assert property (so[1] |->
    $past(sense_in.actuator_detected, 3) && $past(sense_in.pin_locked, 3))
    else $error("outputs high without cause");
  chk_act_gone: assert property (!sense_in.actuator_detected [*4] |->
    so == 2'h0) else $error("outputs high without actuator");
  chk_present_on: assert property (sense_in.actuator_detected [*3] |=>
    actuator_present_out) else $error("presence output missing");
  chk_fault_low: assert property (fault [*2] |-> so == 2'h0)
    else $error("outputs high in fault");
  chk_fault_hold: assert property (fault |=> fault && $stable(error_code))
    else $error("fault not held");
  chk_quiet_hold: assert property (low_r > PROC_TIME + 8 && !fault |->
    $stable(solenoid_drive)) else $error("pin moved while idle");
  chk_short_fault: assert property ((safety_readback != so) [*5] |->
    fault) else $error("cross-short missed");
  cover property ($rose(solenoid_drive));
  cover property ($fell(solenoid_drive) && !fault);
  cover property (fault && error_code == lock_pkg::ERR_CROSS_SHORT);
endmodule
bind guard_lock_interlock_logic lock_chk #(.PROC_TIME(PROC_TIME)) lock_chk_i (
  .clock(clock), .rst_n(rst_n), .lock_request_ch1(lock_request_ch1),
  .lock_request_ch2(lock_request_ch2), .sense_in(sense_in),
  .safety_output_channel(safety_output_channel),
  .safety_readback(safety_readback), .solenoid_drive(solenoid_drive),
  .actuator_present_out(actuator_present_out), .fault(fault),
  .error_code(error_code));

//--- test/ctrl_model.sv
// Purpose: safety controller pulsing the two solenoid requests
// Assumes: driven on the falling clock edge
// Notes: the second channel may be withheld to probe pairing
module ctrl_model (
  input  wire logic clock,
  output logic      req_a,
  output logic      req_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_a = 1'h0;
    req_b = 1'h0;
  end
  // requests drop to idle after every pulse; unlock pulses are only
  // issued by the bench once motion has stopped
  task automatic pulse(input int n, input logic both);
    @(negedge clock);
    req_a = 1'h1;
    req_b = both;
    repeat (n) @(negedge clock);
    req_a = 1'h0;
    req_b = 1'h0;
  endtask
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the guard locking logic
// Assumes: short pulse window 15..25 clocks, processing time 4
// Notes: pin sense follows the solenoid drive, like the real bolt
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PMIN = 15;
  localparam int PMAX = 25;
  typedef struct packed {logic a; int n; logic b; logic [3:0] e;} row_t;
  // expected nibble is presence, both safety channels, solenoid
  localparam row_t rows [9] = '{'{1, 0, 1, 4'h8}, '{1, PMIN - 1, 1, 4'h8},
    '{1, PMAX + 1, 1, 4'h8}, '{1, PMIN, 1, 4'hf}, '{1, PMIN, 0, 4'hf},
    '{1, PMAX, 1, 4'h8}, '{0, PMIN, 1, 4'h1}, '{1, 0, 1, 4'hf},
    '{0, 0, 1, 4'h1}};
  logic clock = 1'h0, rst_n = 1'h0, act = 1'h0;
  logic aux = 1'h0, bad = 1'h0, shrt = 1'h0;
  wire logic r1, r2, sol, flt, pres;
  wire logic [3:0] code;
  wire lock_pkg::safety_pair_t so;
  // a short shows as the second pin reading back inverted
  wire lock_pkg::safety_pair_t rb = {so.ch1, so.ch2 ^ shrt};
  wire lock_pkg::sense_t sn = {act, sol, aux, bad};
  int n_mismatch = 0, checks_done = 0;
  always #10 clock = ~clock;
  ctrl_model ctrl_model_i (.clock(clock), .req_a(r1), .req_b(r2));
  guard_lock_interlock_logic #(.PULSE_MIN(PMIN), .PULSE_MAX(PMAX),
    .PROC_TIME(4)) guard_lock_interlock_logic_i (.clock(clock),
    .rst_n(rst_n), .lock_request_ch1(r1), .lock_request_ch2(r2),
    .sense_in(sn), .safety_readback(rb), .safety_output_channel(so),
    .actuator_present_out(pres), .solenoid_drive(sol), .fault(flt),
    .error_code(code));
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic reset_dut;
    rst_n = 1'h0;
    {aux, bad, shrt} = 3'h0;
    repeat (20) @(negedge clock);
    rst_n = 1'h1;
    @(negedge clock);
    check({flt, so, sol}, 4'h0);
  endtask
  task automatic fault_case(input int k, input logic [3:0] c);
    reset_dut;
    act = 1'h1;
    ctrl_model_i.pulse(PMIN, 1'h1);
    repeat (12) @(negedge clock);
    {aux, bad, shrt} = 3'h4 >> k;
    repeat (12) @(negedge clock);
    check({flt, so, sol}, 4'h8);
    {aux, bad, shrt} = 3'h0;
    ctrl_model_i.pulse(PMIN, 1'h1);
    repeat (12) @(negedge clock);
    check({flt, so, sol}, 4'h8);
    check(code, c);
  endtask
  initial begin
    reset_dut;
    foreach (rows[i]) begin
      act = rows[i].a;
      if (rows[i].n > 0) ctrl_model_i.pulse(rows[i].n, rows[i].b);
      repeat (12) @(negedge clock);
      check({pres, so, sol}, rows[i].e);
    end
    fault_case(0, lock_pkg::ERR_AUX_RELEASE);
    fault_case(1, lock_pkg::ERR_AUX_NOT_RESTORED);
    fault_case(2, lock_pkg::ERR_CROSS_SHORT);
    reset_dut;
    final_report;
  end
endmodule
